// *** logic/srp_serial_port.sv ***
`timescale 1ns/1ns
// Functional notes
// - line rates 300 to 115200 baud are chosen by the baud select field.
// - parity none, even or odd is generated on transmit and checked on receive.
// - forced-low mode holds the request line low all the time.
// - forced-high mode holds the request line high all the time.
// - keyed mode raises the request line only for the leading delay, the transmission and the trailing delay.
// - keyed mode waits the leading delay after raising the line before the first character.
// - both keyed modes hold the line for the trailing delay after the last character.
// - leading and trailing delays count one step per millisecond.
// - handshake mode raises the line and waits for clear-to-send before the first character.
// - handshake mode applies the leading delay after clear-to-send, none when zero.
// - handshake mode discards the pending byte when clear-to-send stays off 10 s.
// - a half-duplex transceiver needs a keyed mode since the line steers its driver.
// - with logging on every sent and received byte is copied to the log output.
module srp_serial_port
  import srp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES,
  parameter int TMO_MS = CTS_TIMEOUT_MS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire srp_cfg_t   cfg,
  input  wire logic [7:0] txByte,
  input  wire logic       txValid,
  input  wire logic       rxPin,
  input  wire logic       ctsPin,
  output logic            txReady,
  output logic            txDiscard,
  output logic            txPin,
  output logic            rtsPin,
  output logic [7:0]      rxByte,
  output logic            rxValid,
  output logic            rxParityErr,
  output logic            rxFrameErr,
  output srp_log_t        logOut
);
  logic             rxMeta_reg, rxSync_reg, ctsMeta_reg, ctsSync_reg;
  logic [MS_W-1:0]  msDiv_reg, msDiv_next;
  logic             msTick;
  srp_tx_state_t    state_reg, state_next;
  logic [7:0]       hold_reg, hold_next;
  logic             holdValid_reg, holdValid_next;
  logic [FRM_W-1:0] shift_reg, shift_next, frame;
  logic [LEN_W-1:0] len_reg, len_next, frameLen, bitCnt_reg, bitCnt_next;
  logic [DIV_W-1:0] baudCnt_reg, baudCnt_next, baudDiv;
  logic [DLY_W-1:0] delay_reg, delay_next;
  logic [TMO_W-1:0] tmo_reg, tmo_next;
  logic             txPin_next, rtsPin_next, txReady_next, discard_next;
  logic             load, keyed;
  srp_log_t         logOut_next;
  logic [7:0]       rxByteW;
  logic             rxStrobeW;

  assign baudDiv = srp_baud_div(cfg.baudSel);
  assign keyed   = cfg.rtsMode == REQUEST_KEYED_BY_TRANSMIT
                || cfg.rtsMode == CLEAR_GATED_HANDSHAKE;
  assign msTick  = msDiv_reg == MS_W'(MS_CYC - 1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxMeta_reg  <= 1'b1;
      rxSync_reg  <= 1'b1;
      ctsMeta_reg <= 1'b0;
      ctsSync_reg <= 1'b0;
    end else begin
      rxMeta_reg  <= rxPin;
      rxSync_reg  <= rxMeta_reg;
      ctsMeta_reg <= ctsPin;
      ctsSync_reg <= ctsMeta_reg;
    end
  end

  // millisecond divider, restarted on each state change
  always_comb begin
    if (state_next != state_reg || msTick) msDiv_next = '0;
    else msDiv_next = msDiv_reg + 1'b1;
  end

  // frame image, lsb first: start, data, parity, stop bits
  always_comb begin
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || !cfg.sevenBit) frame[1+i] = hold_reg[i];
    end
    if (cfg.sevenBit) frame[8] = 1'b1;
    if (cfg.parity != PAR_NONE) begin
      frame[cfg.sevenBit ? 8 : 9] =
        srp_par_bit(hold_reg, cfg.sevenBit, cfg.parity);
    end
    frameLen = (cfg.sevenBit ? 4'h8 : 4'h9)
             + ((cfg.parity != PAR_NONE) ? 4'h1 : 4'h0)
             + (cfg.twoStop ? 4'h2 : 4'h1);
  end

  always_comb begin
    state_next     = state_reg;
    hold_next      = hold_reg;
    holdValid_next = holdValid_reg;
    shift_next     = shift_reg;
    len_next       = len_reg;
    bitCnt_next    = bitCnt_reg;
    baudCnt_next   = baudCnt_reg;
    delay_next     = delay_reg;
    tmo_next       = tmo_reg;
    txPin_next     = txPin;
    discard_next   = 1'b0;
    load           = 1'b0;
    if (txValid && !holdValid_reg) begin
      hold_next      = txByte;
      holdValid_next = 1'b1;
    end
    case (state_reg)
      TX_IDLE: if (holdValid_reg) begin
        case (cfg.rtsMode)
          REQUEST_KEYED_BY_TRANSMIT: begin
            state_next = TX_LEAD;
            delay_next = cfg.leadMs;
          end
          CLEAR_GATED_HANDSHAKE: begin
            state_next = TX_WAIT;
            tmo_next   = '0;
          end
          default: load = 1'b1;
        endcase
      end
      TX_LEAD: begin
        if (delay_reg == '0) load = 1'b1;
        else if (msTick) delay_next = delay_reg - 1'b1;
      end
      TX_WAIT: begin
        if (ctsSync_reg) begin
          if (cfg.leadMs == '0) load = 1'b1;
          else begin
            state_next = TX_LEAD;
            delay_next = cfg.leadMs;
          end
        end else if (msTick) begin
          if (tmo_reg == TMO_W'(TMO_MS - 1)) begin
            state_next     = TX_IDLE;
            holdValid_next = 1'b0;
            discard_next   = 1'b1;
          end else tmo_next = tmo_reg + 1'b1;
        end
      end
      TX_SEND: begin
        if (baudCnt_reg == baudDiv - 1'b1) begin
          baudCnt_next = '0;
          if (bitCnt_reg == len_reg - 1'b1) begin
            if (holdValid_reg) load = 1'b1;
            else if (keyed) begin
              state_next = TX_TRAIL;
              delay_next = cfg.trailMs;
            end else state_next = TX_IDLE;
          end else begin
            bitCnt_next = bitCnt_reg + 1'b1;
            shift_next  = shift_reg >> 1;
            txPin_next  = shift_reg[1];
          end
        end else baudCnt_next = baudCnt_reg + 1'b1;
      end
      TX_TRAIL: begin
        if (holdValid_reg) load = 1'b1;
        else if (delay_reg == '0) state_next = TX_IDLE;
        else if (msTick) delay_next = delay_reg - 1'b1;
      end
      default: state_next = TX_IDLE;
    endcase
    if (load) begin
      state_next     = TX_SEND;
      shift_next     = frame;
      len_next       = frameLen;
      bitCnt_next    = '0;
      baudCnt_next   = '0;
      txPin_next     = 1'b0;
      holdValid_next = 1'b0;
    end
    case (cfg.rtsMode)
      REQUEST_LINE_FORCED_LOW:  rtsPin_next = 1'b0;
      REQUEST_LINE_FORCED_HIGH: rtsPin_next = 1'b1;
      default: rtsPin_next = state_next != TX_IDLE;
    endcase
    txReady_next = !holdValid_next;
    logOut_next.txStrobe = load && cfg.linkByteLogging;
    logOut_next.txByte   = hold_reg;
    logOut_next.rxStrobe = rxStrobeW && cfg.linkByteLogging;
    logOut_next.rxByte   = rxByteW;
  end

  assign rxByte  = rxByteW;
  assign rxValid = rxStrobeW;

  srp_rx u_rx (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .rxLine    (rxSync_reg),
    .cfg       (cfg),
    .baudDiv   (baudDiv),
    .rxByte    (rxByteW),
    .rxStrobe  (rxStrobeW),
    .parityErr (rxParityErr),
    .frameErr  (rxFrameErr)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      msDiv_reg     <= '0;
      state_reg     <= TX_IDLE;
      hold_reg      <= '0;
      holdValid_reg <= 1'b0;
      shift_reg     <= '1;
      len_reg       <= '0;
      bitCnt_reg    <= '0;
      baudCnt_reg   <= '0;
      delay_reg     <= '0;
      tmo_reg       <= '0;
      txPin         <= 1'b1;
      rtsPin        <= 1'b0;
      txReady       <= 1'b1;
      txDiscard     <= 1'b0;
      logOut        <= '0;
    end else begin
      msDiv_reg     <= msDiv_next;
      state_reg     <= state_next;
      hold_reg      <= hold_next;
      holdValid_reg <= holdValid_next;
      shift_reg     <= shift_next;
      len_reg       <= len_next;
      bitCnt_reg    <= bitCnt_next;
      baudCnt_reg   <= baudCnt_next;
      delay_reg     <= delay_next;
      tmo_reg       <= tmo_next;
      txPin         <= txPin_next;
      rtsPin        <= rtsPin_next;
      txReady       <= txReady_next;
      txDiscard     <= discard_next;
      logOut        <= logOut_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  baud_divisor_a: assert property (cfg.baudSel == 4'h0 |->
    baudDiv == DIV_W'(CLK_FREQ_HZ / 300)) else $error("bad 300 baud divisor");
  baud_fast_a: assert property (cfg.baudSel == 4'h9 |->
    baudDiv == DIV_W'(CLK_FREQ_HZ / 115200)) else $error("bad fast divisor");
  tx_parity_a: assert property (load && cfg.parity == PAR_EVEN
    |-> ^frame[9:1] == 1'b0 || cfg.sevenBit) else $error("bad even parity");
  forced_low_a: assert property ($past(cfg.rtsMode) ==
    REQUEST_LINE_FORCED_LOW |-> !rtsPin) else $error("request line not low");
  forced_high_a: assert property ($past(cfg.rtsMode) ==
    REQUEST_LINE_FORCED_HIGH |-> rtsPin) else $error("request line not high");
  keyed_idle_a: assert property ($past(keyed) && $stable(cfg.rtsMode)
    |-> rtsPin == (state_reg != TX_IDLE)) else $error("keyed line wrong");
  lead_quiet_a: assert property (state_reg == TX_LEAD
    |-> txPin && delay_reg <= cfg.leadMs) else $error("sent during lead");
  trail_hold_a: assert property (state_reg == TX_TRAIL && $past(keyed)
    |-> rtsPin) else $error("line dropped in trail");
  ms_step_a: assert property (state_reg == TX_LEAD && $past(state_reg) ==
    TX_LEAD && delay_reg != $past(delay_reg) |-> $past(msTick))
    else $error("delay stepped off tick");
  cts_gate_a: assert property (state_reg == TX_WAIT && !ctsSync_reg
    |=> state_reg != TX_SEND) else $error("sent without clear-to-send");
  zero_lead_a: assert property (state_reg == TX_WAIT && ctsSync_reg &&
    cfg.leadMs == '0 |=> state_reg == TX_SEND) else $error("zero lead delayed");
  timeout_a: assert property (txDiscard |-> $past(state_reg) == TX_WAIT
    && state_reg == TX_IDLE && !$past(ctsSync_reg)) else $error("bad discard");
  log_tx_a: assert property (load && cfg.linkByteLogging |=>
    logOut.txStrobe && logOut.txByte == $past(hold_reg)) else $error("no log");
  stop_done_a: assert property (state_reg == TX_SEND && state_next ==
    TX_TRAIL |-> txPin && bitCnt_reg == len_reg - 1'b1 &&
    baudCnt_reg == baudDiv - 1'b1) else $error("trail before stop end");

  keyed_frame_c: cover property (state_reg == TX_TRAIL ##1
    state_reg == TX_IDLE);
  handshake_c: cover property (state_reg == TX_WAIT && ctsSync_reg);
  discard_c: cover property (txDiscard);
  rx_log_c: cover property (logOut.rxStrobe);
endmodule : srp_serial_port

// *** logic/srp_pkg.sv ***
package srp_pkg;
  localparam int CLK_FREQ_HZ    = 250_000_000;
  localparam int MS_TIME        = 1;
  localparam int MS_CYCLES      = CLK_FREQ_HZ / 1000 * MS_TIME;
  localparam int CTS_TIMEOUT_S  = 10;
  localparam int CTS_TIMEOUT_MS = CTS_TIMEOUT_S * 1000;
  localparam int NUM_BAUDS      = 10;
  localparam int BAUD_RATES [NUM_BAUDS] = '{300, 600, 1200, 2400, 4800,
    9600, 19200, 38400, 57600, 115200};
  localparam logic [3:0] BAUD_SEL_DEFAULT = 4'h5;
  localparam int DIV_W = 20;
  localparam int MS_W  = 18;
  localparam int TMO_W = 14;
  localparam int DLY_W = 16;
  localparam int FRM_W = 12;
  localparam int LEN_W = 4;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD  = 2'h2
  } srp_parity_t;

  typedef enum logic [1:0] {
    REQUEST_LINE_FORCED_LOW   = 2'h0,
    REQUEST_LINE_FORCED_HIGH  = 2'h1,
    REQUEST_KEYED_BY_TRANSMIT = 2'h2,
    CLEAR_GATED_HANDSHAKE     = 2'h3
  } srp_rts_mode_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_LEAD = 5'h02,
    TX_WAIT = 5'h04,
    TX_SEND = 5'h08,
    TX_TRAIL = 5'h10
  } srp_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } srp_rx_state_t;

  typedef struct packed {
    logic [3:0]         baudSel;
    srp_parity_t        parity;
    logic               sevenBit;
    logic               twoStop;
    srp_rts_mode_t      rtsMode;
    logic [DLY_W-1:0]   leadMs;
    logic [DLY_W-1:0]   trailMs;
    logic               linkByteLogging;
  } srp_cfg_t;

  typedef struct packed {
    logic       txStrobe;
    logic [7:0] txByte;
    logic       rxStrobe;
    logic [7:0] rxByte;
  } srp_log_t;

  function automatic logic [DIV_W-1:0] srp_baud_div(input logic [3:0] sel);
    int idx;
    idx = (int'(sel) < NUM_BAUDS) ? int'(sel) : int'(BAUD_SEL_DEFAULT);
    return DIV_W'(CLK_FREQ_HZ / BAUD_RATES[idx]);
  endfunction : srp_baud_div

  function automatic logic srp_par_bit(input logic [7:0] d,
                                       input logic seven,
                                       input srp_parity_t par);
    logic x;
    x = ^(seven ? {1'b0, d[6:0]} : d);
    return (par == PAR_ODD) ? ~x : x;
  endfunction : srp_par_bit
endpackage : srp_pkg

// *** logic/srp_rx.sv ***
`timescale 1ns/1ns
module srp_rx
  import srp_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             rxLine,
  input  wire srp_cfg_t         cfg,
  input  wire logic [DIV_W-1:0] baudDiv,
  output logic [7:0]            rxByte,
  output logic                  rxStrobe,
  output logic                  parityErr,
  output logic                  frameErr
);
  srp_rx_state_t    state_reg, state_next;
  logic [DIV_W-1:0] cnt_reg, cnt_next;
  logic [3:0]       idx_reg, idx_next;
  logic [8:0]       buf_reg, buf_next;
  logic [7:0]       byte_next;
  logic             strobe_next, perr_next, ferr_next;
  logic [3:0]       nBits;
  logic [7:0]       dataVal;

  assign nBits = (cfg.sevenBit ? 4'h7 : 4'h8)
               + ((cfg.parity != PAR_NONE) ? 4'h1 : 4'h0);
  assign dataVal = cfg.sevenBit ? {1'b0, buf_reg[6:0]} : buf_reg[7:0];

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg + 1'b1;
    idx_next    = idx_reg;
    buf_next    = buf_reg;
    byte_next   = rxByte;
    strobe_next = 1'b0;
    perr_next   = parityErr;
    ferr_next   = frameErr;
    case (state_reg)
      RX_IDLE: begin
        cnt_next = '0;
        if (!rxLine) state_next = RX_START;
      end
      RX_START: if (cnt_reg == (baudDiv >> 1)) begin
        cnt_next = '0;
        idx_next = '0;
        state_next = rxLine ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (cnt_reg == baudDiv - 1'b1) begin
        cnt_next = '0;
        buf_next[idx_reg] = rxLine;
        idx_next = idx_reg + 1'b1;
        if (idx_reg == nBits - 1'b1) state_next = RX_STOP;
      end
      RX_STOP: if (cnt_reg == baudDiv - 1'b1) begin
        state_next  = RX_IDLE;
        byte_next   = dataVal;
        strobe_next = 1'b1;
        ferr_next   = !rxLine;
        perr_next   = (cfg.parity != PAR_NONE) &&
          (buf_reg[cfg.sevenBit ? 7 : 8] !=
           srp_par_bit(dataVal, cfg.sevenBit, cfg.parity));
      end
      default: state_next = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= RX_IDLE;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      buf_reg   <= '0;
      rxByte    <= '0;
      rxStrobe  <= 1'b0;
      parityErr <= 1'b0;
      frameErr  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      buf_reg   <= buf_next;
      rxByte    <= byte_next;
      rxStrobe  <= strobe_next;
      parityErr <= perr_next;
      frameErr  <= ferr_next;
    end
  end
endmodule : srp_rx

// *** bench/srp_peer.sv ***
`timescale 1ns/1ns
module srp_peer #(
  parameter int BIT = 2170
) (
  input  wire logic sys_clk,
  input  wire logic txPin,
  input  wire logic rtsPin,
  output logic      rxPin,
  output logic      ctsPin
);
  logic ctsOn = 1'b0;

  initial begin
    rxPin  = 1'b1;
    ctsPin = 1'b0;
  end

  // grant only while the request line is up
  always @(posedge sys_clk) begin
    ctsPin <= ctsOn & rtsPin;
  end

  // start bit, then bits lsb first, one bit time each
  task automatic put(input logic [11:0] f, input int k);
    rxPin <= 1'b0;
    repeat (BIT) @(posedge sys_clk);
    for (int i = 0; i < k; i++) begin
      rxPin <= f[i];
      repeat (BIT) @(posedge sys_clk);
    end
    rxPin <= 1'b1;
  endtask : put

  // called at the start bit edge; samples each bit at its centre
  task automatic get(input int k, output logic [11:0] f);
    f = '0;
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < k; i++) begin
      repeat (BIT) @(posedge sys_clk);
      f[i] = txPin;
    end
  endtask : get
endmodule : srp_peer

// *** bench/srp_serial_port_bench.sv ***
`timescale 1ns/1ns
module srp_serial_port_bench import srp_pkg::*;;
  localparam int BIT = 2170;
  localparam int MS  = 20;
  localparam int TMO = 5;

  logic        sys_clk;
  logic        rst;
  logic        txValid;
  logic        rxPin;
  logic        ctsPin;
  logic        txReady;
  logic        txDiscard;
  logic        txPin;
  logic        rtsPin;
  logic        rxValid;
  logic        rxParityErr;
  logic        rxFrameErr;
  logic [7:0]  txByte;
  logic [7:0]  rxByte;
  srp_cfg_t    cfg;
  srp_log_t    logOut;
  logic [11:0] bits;
  int          n;
  int          failures;
  int          totalChecks;

  srp_serial_port #(.MS_CYC(MS), .TMO_MS(TMO)) dut (
    .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .txByte(txByte),
    .txValid(txValid), .rxPin(rxPin), .ctsPin(ctsPin), .txReady(txReady),
    .txDiscard(txDiscard), .txPin(txPin), .rtsPin(rtsPin),
    .rxByte(rxByte), .rxValid(rxValid), .rxParityErr(rxParityErr),
    .rxFrameErr(rxFrameErr), .logOut(logOut)
  );

  srp_peer #(.BIT(BIT)) peer (
    .sys_clk(sys_clk), .txPin(txPin), .rtsPin(rtsPin),
    .rxPin(rxPin), .ctsPin(ctsPin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    if (failures == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int v, input int lo,
                     input int hi);
    totalChecks++;
    if (v < lo || v > hi) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, v);
    end
  endtask : rng

  // counts edges until the chosen output shows v
  task automatic waitfor(input int w, input logic v, output int c);
    c = 0;
    while ((w == 0 ? txPin : w == 1 ? rtsPin : w == 2 ? txDiscard :
            w == 3 ? rxValid : logOut.txStrobe) !== v && c < 30000) begin
      @(posedge sys_clk);
      c++;
    end
    if (c >= 30000) begin
      failures++;
      $display("[ERR] wait%0d expected %0d seen none", w, v);
    end
  endtask : waitfor

  task automatic send(input logic [7:0] b);
    chk("txReady", 12'h001, {11'h0, txReady});
    txByte  <= b;
    txValid <= 1'b1;
    @(posedge sys_clk);
    txValid <= 1'b0;
  endtask : send

  task automatic rxw(input logic [11:0] f, input int k,
                     input logic [7:0] eb, input logic pe);
    int c;
    fork
      peer.put(f, k);
      begin
        waitfor(3, 1'b1, c);
        chk("rxByte", {4'h0, eb}, {4'h0, rxByte});
        chk("rxParityErr", {11'h0, pe}, {11'h0, rxParityErr});
        chk("rxFrameErr", 12'h000, {11'h0, rxFrameErr});
        @(posedge sys_clk);
        chk("logRx", {4'h1, eb}, {3'h0, logOut.rxStrobe, logOut.rxByte});
      end
    join
  endtask : rxw

  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  initial begin
    failures = 0;
    totalChecks = 0;
    rst = 1'b1;
    txValid = 1'b0;
    txByte = 8'h00;
    cfg = '{baudSel: 4'h9, parity: PAR_EVEN, sevenBit: 1'b0,
           twoStop: 1'b0, rtsMode: REQUEST_LINE_FORCED_LOW,
           leadMs: 16'h0002, trailMs: 16'h0001, linkByteLogging: 1'b1};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("txPinIdle", 12'h001, {11'h0, txPin});
    // full duplex, forced low, 8 bits even parity, logging on
    fork
      begin
        send(8'h96);
        waitfor(4, 1'b1, n);
        chk("logTx", 12'h096, {4'h0, logOut.txByte});
        waitfor(0, 1'b0, n);
        peer.get(10, bits);
        chk("txFrame", {3'b001, ^8'h96, 8'h96}, bits);
        chk("rtsLow", 12'h000, {11'h0, rtsPin});
        repeat (BIT) @(posedge sys_clk);
      end
      rxw({3'b001, ^8'h3c, 8'h3c}, 10, 8'h3c, 1'b0);
    join
    cfg.rtsMode <= REQUEST_LINE_FORCED_HIGH;
    repeat (3) @(posedge sys_clk);
    chk("rtsHigh", 12'h001, {11'h0, rtsPin});
    cfg.rtsMode <= REQUEST_KEYED_BY_TRANSMIT;
    cfg.parity <= PAR_ODD;
    cfg.sevenBit <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // keyed send while a 7-bit byte with bad parity arrives
    fork
      begin
        repeat (BIT) @(posedge sys_clk);
        chk("rtsRx", 12'h000, {11'h0, rtsPin});
        send(8'h4b);
        waitfor(1, 1'b1, n);
        rng("rtsRise", n, 0, 2);
        waitfor(0, 1'b0, n);
        rng("lead", n, 2 * MS, 2 * MS + 4);
        peer.get(9, bits);
        chk("txFrame7", {4'b0001, ~^7'h4b, 7'h4b}, bits);
        chk("rtsKeep", 12'h001, {11'h0, rtsPin});
        waitfor(1, 1'b0, n);
        rng("trail", n, BIT / 2 + MS - 2, BIT / 2 + MS + 6);
      end
      rxw({4'b0001, ^7'h31, 7'h31}, 9, 8'h31, 1'b1);
    join
    cfg.rtsMode <= CLEAR_GATED_HANDSHAKE;
    cfg.parity <= PAR_NONE;
    cfg.sevenBit <= 1'b0;
    cfg.twoStop <= 1'b1;
    cfg.leadMs <= 16'h0000;
    @(posedge sys_clk);
    send(8'hc3);
    repeat (2) @(posedge sys_clk);
    chk("rtsWait", 12'h001, {11'h0, rtsPin});
    chk("txBusy", 12'h000, {11'h0, txReady});
    waitfor(2, 1'b1, n);
    rng("ctsTimeout", n, TMO * MS - 2, TMO * MS + MS + 4);
    chk("txHeld", 12'h001, {11'h0, txPin});
    repeat (2) @(posedge sys_clk);
    chk("rtsDrop", 12'h000, {11'h0, rtsPin});
    peer.ctsOn <= 1'b1;
    send(8'hc3);
    waitfor(0, 1'b0, n);
    rng("ctsStart", n, 2, 10);
    peer.get(10, bits);
    chk("txFrameHs", 12'h3c3, bits);
    waitfor(1, 1'b0, n);
    rng("trailHs", n, BIT / 2 + MS - 2, BIT / 2 + MS + 6);
    close_out();
  end
endmodule : srp_serial_port_bench
